/* File: rtl/rcb_pkg.sv */
// Shared constants and carrier types for the ring claim/beacon/status engine.
// Assumes one ring-side clock shared by the PHY symbol path and the AXI4-Lite bus.
package rcb_pkg;
	// Register byte offsets
	localparam logic [7:0] OFS_OPTION   = 8'h00;
	localparam logic [7:0] OFS_FUNCTION = 8'h04;
	localparam logic [7:0] OFS_RROT     = 8'h08;
	localparam logic [7:0] OFS_BTYPE    = 8'h0c;
	localparam logic [7:0] OFS_STATUS   = 8'h10;
	// Option bits
	localparam int OPT_EXT_ACK     = 0;
	localparam int OPT_INH_RECOV   = 1;
	localparam int OPT_INH_RELEASE = 2;
	localparam logic [2:0] OPTION_RESET = 3'h0;
	// Function bits, write one to act
	localparam int FN_CLAIM  = 0;
	localparam int FN_BEACON = 1;
	// Status fields
	localparam int ST_STATE_LSB = 0;
	localparam int ST_RINGOP    = 3;
	localparam int ST_CLSUB_LSB = 4;
	localparam int ST_BNSUB_LSB = 6;
	localparam int ST_KIND_LSB  = 8;
	// Requested rotation time, count of 20.48 us steps
	localparam int RROT_WIDTH = 16;
	localparam logic [15:0] RROT_RESET  = 16'h0000;
	localparam logic [31:0] BTYPE_RESET = 32'h0000_0000;
	// Indicator symbols and positions
	localparam logic [1:0] SYM_R = 2'h0;
	localparam logic [1:0] SYM_S = 2'h1;
	localparam logic [1:0] SYM_T = 2'h2;
	localparam logic [1:0] POS_E = 2'h0;
	localparam logic [1:0] POS_A = 2'h1;
	localparam logic [1:0] POS_C = 2'h2;
	// Received MAC frame kinds
	localparam logic [1:0] KIND_NONE   = 2'h0;
	localparam logic [1:0] KIND_CLAIM  = 2'h1;
	localparam logic [1:0] KIND_BEACON = 2'h2;
	localparam logic [1:0] KIND_OTHER  = 2'h3;
	// Claim subtypes
	localparam logic [1:0] CL_NONE   = 2'h0;
	localparam logic [1:0] CL_OWN    = 2'h1;
	localparam logic [1:0] CL_HIGHER = 2'h2;
	localparam logic [1:0] CL_LOWER  = 2'h3;
	// Beacon subtypes
	localparam logic [1:0] BN_NONE  = 2'h0;
	localparam logic [1:0] BN_OWN   = 2'h1;
	localparam logic [1:0] BN_OTHER = 2'h2;
	// Immediate service classes
	localparam logic [3:0] CLS_IMM  = 4'h5;
	localparam logic [3:0] CLS_IMMN = 4'h6;
	localparam logic [3:0] CLS_IMMR = 4'h7;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0]
	{
		ST_IDLE   = 3'b001,
		ST_CLAIM  = 3'b010,
		ST_BEACON = 3'b100
	} rcb_state_type;

	typedef struct packed
	{
		logic       valid;
		logic       aligned;
		logic [1:0] pos;
		logic [1:0] sym;
	} rcb_ind_type;

	typedef struct packed
	{
		logic       valid;
		logic [1:0] sym;
	} rcb_tx_ind_type;

	typedef struct packed
	{
		logic        valid;
		logic [1:0]  kind;
		logic        sa_match_long;
		logic        sa_match_short;
		logic [31:0] bid;
	} rcb_mac_frame_type;

	typedef struct packed
	{
		logic        valid;
		logic        beacon;
		logic [31:0] info;
	} rcb_gen_type;

	typedef struct packed
	{
		logic [1:0] kind;
		logic [1:0] claim_sub;
		logic [1:0] beacon_sub;
	} rcb_report_type;
endpackage

/* File: rtl/rcb_ring_engine.sv */
// Frame status rewriting, claim/beacon classification and claim/beacon state logic.
// Assumes PHY symbols, framer and request logic all run on aclk; registers over AXI4-Lite.
`timescale 1ns/1ps
// Operation
// - Rewrite indicators only when they arrive byte aligned after the delimiter.
// - Error flag from FCS fail or E not R; then send E=S, repeat A,C.
// - Address flag from matcher, or from external acknowledge pin when option set.
// - Copy flag is copy-valid input delayed by exactly one clock.
// - Next-station-announce flag sampled when A indicator is examined.
// - A=R, no error: unaddressed repeat; addressed send A=S, C=S if copied else R.
// - A=S on announce frame without error: send A=S and C=R.
// - Any valid MAC frame clears ring-operational; frames may select Idle or Claim, never Beacon.
// - Claim subtypes own, higher, lower from address match and bid versus requested time.
// - Claim state sends own Claims; immediate claims only after one internal Claim.
// - Internal Claim info is 4-byte requested rotation time, 20.48 us steps.
// - Recovery enters claim: late rotation expiry, transmission timer expiry, lower claim, own beacon.
// - Writing 1 to force-claim enters claim even with recovery inhibited.
// - In claim, higher claim goes Idle; lower claim keeps claiming.
// - Own claim wins and issues token, unless inhibit-release keeps claim state.
// - Beacon subtype own when long or short address matches, else other.
// - Beacon state sends own Beacons; immediate beacons only after one internal Beacon.
// - Internal Beacon info carries programmed beacon-type value.
// - Enter beacon on rotation expiry during claim or force-beacon write.
// - Other beacon while beaconing: leave beacon, stop own, repeat incoming.
// - Own beacon returned: beacon succeeded, proceed to claim.
module rcb_ring_engine
	import rcb_pkg::*;
#(
	parameter int ADDR_W = 8
)
(
	input  wire logic                      aclk,
	input  wire logic                      aresetn,
	input  wire logic [ADDR_W-1:0]         s_axi_awaddr,
	input  wire logic                      s_axi_awvalid,
	output logic                           s_axi_awready,
	input  wire logic [31:0]               s_axi_wdata,
	input  wire logic [3:0]                s_axi_wstrb,
	input  wire logic                      s_axi_wvalid,
	output logic                           s_axi_wready,
	output logic [1:0]                     s_axi_bresp,
	output logic                           s_axi_bvalid,
	input  wire logic                      s_axi_bready,
	input  wire logic [ADDR_W-1:0]         s_axi_araddr,
	input  wire logic                      s_axi_arvalid,
	output logic                           s_axi_arready,
	output logic [31:0]                    s_axi_rdata,
	output logic [1:0]                     s_axi_rresp,
	output logic                           s_axi_rvalid,
	input  wire logic                      s_axi_rready,
	input  wire rcb_pkg::rcb_ind_type      rx_ind,
	input  wire logic                      fcs_error,
	input  wire logic                      addr_match,
	input  wire logic                      ext_ack_input,
	input  wire logic                      copy_valid_input,
	input  wire logic                      next_station_announce,
	output rcb_pkg::rcb_tx_ind_type        tx_ind,
	input  wire rcb_pkg::rcb_mac_frame_type mac_frame,
	input  wire logic                      token_rotation_timer_expire,
	input  wire logic                      late_flag,
	input  wire logic                      valid_transmission_timer_expire,
	output rcb_pkg::rcb_gen_type           gen_frame,
	input  wire logic                      gen_done,
	input  wire logic                      immediate_claim_qualifier,
	input  wire logic                      immediate_beacon_qualifier,
	input  wire logic [3:0]                req_class,
	input  wire logic                      imm_frame_ready,
	output logic                           imm_grant,
	output logic                           token_issue,
	output logic                           ring_operational,
	output rcb_pkg::rcb_state_type         ring_state,
	output rcb_pkg::rcb_report_type        rx_report
);
	import rcb_pkg::*;

	// Offsets decode from the low eight address bits
	if (ADDR_W < 8 || ADDR_W > 32)
		$error("ADDR_W must hold the register map");

	function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] data,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++)
			if (strb[i])
				res[8*i +: 8] = data[8*i +: 8];
		return res;
	endfunction

	function automatic logic is_immediate(input logic [3:0] cls);
		return (cls == CLS_IMM) || (cls == CLS_IMMN) || (cls == CLS_IMMR);
	endfunction

	// Register bus state
	logic                  aw_full_reg;
	logic                  w_full_reg;
	logic [ADDR_W-1:0]     awaddr_reg;
	logic [31:0]           wdata_reg;
	logic [3:0]            wstrb_reg;
	logic [2:0]            option_reg;
	logic [RROT_WIDTH-1:0] rrot_reg;
	logic [31:0]           btype_reg;
	logic                  force_claim_reg;
	logic                  force_beacon_reg;
	logic                  do_write;
	logic [31:0]           opt_word;
	logic [31:0]           rrot_word;
	logic [31:0]           status_word;

	// Ring state
	rcb_state_type  state_reg;
	rcb_state_type  state_next;
	logic           sent_one_reg;
	logic           issue_next;
	logic [1:0]     claim_sub;
	logic [1:0]     beacon_sub;
	logic           lower_claim;
	logic           higher_claim;
	logic           own_claim;
	logic           own_beacon;
	logic           other_beacon;
	logic           recovery;

	// Indicator path
	logic           copy_flag_reg;
	logic           e_flag_reg;
	logic           a_flag_reg;
	logic           a_rcv_s_reg;
	logic           ann_reg;
	logic           a_flag_now;
	logic           e_now;
	logic [1:0]     tx_sym_next;

	assign do_write = aw_full_reg && w_full_reg && !s_axi_bvalid;
	assign s_axi_awready = !aw_full_reg && !s_axi_bvalid;
	assign s_axi_wready = !w_full_reg && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;

	// Address and data taken in either order, write once both are held
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_full_reg <= 1'b0;
			w_full_reg <= 1'b0;
			awaddr_reg <= '0;
			wdata_reg <= 32'h0000_0000;
			wstrb_reg <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_full_reg <= 1'b1;
				awaddr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_full_reg <= 1'b1;
				wdata_reg <= s_axi_wdata;
				wstrb_reg <= s_axi_wstrb;
			end
			if (do_write)
			begin
				aw_full_reg <= 1'b0;
				w_full_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				unique case (awaddr_reg[7:0] & 8'hfc)
					OFS_OPTION, OFS_FUNCTION, OFS_RROT, OFS_BTYPE, OFS_STATUS:
						s_axi_bresp <= RESP_OKAY;
					default:
						s_axi_bresp <= RESP_SLVERR;
				endcase
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	assign opt_word = {29'h0, option_reg};
	assign rrot_word = {{(32 - RROT_WIDTH){1'b0}}, rrot_reg};

	// Writable registers; function bits self-clear after one cycle
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			option_reg <= OPTION_RESET;
			rrot_reg <= RROT_RESET;
			btype_reg <= BTYPE_RESET;
			force_claim_reg <= 1'b0;
			force_beacon_reg <= 1'b0;
		end
		else
		begin
			force_claim_reg <= 1'b0;
			force_beacon_reg <= 1'b0;
			if (do_write)
			begin
				unique case (awaddr_reg[7:0] & 8'hfc)
					OFS_OPTION:
						option_reg <= 3'(merge_bytes(opt_word, wdata_reg, wstrb_reg));
					OFS_FUNCTION:
					begin
						force_claim_reg <= wstrb_reg[0] && wdata_reg[FN_CLAIM];
						force_beacon_reg <= wstrb_reg[0] && wdata_reg[FN_BEACON];
					end
					OFS_RROT:
						rrot_reg <= RROT_WIDTH'(merge_bytes(rrot_word, wdata_reg, wstrb_reg));
					OFS_BTYPE:
						btype_reg <= merge_bytes(btype_reg, wdata_reg, wstrb_reg);
					default:
						option_reg <= option_reg;
				endcase
			end
		end
	end

	assign status_word = {22'h0, rx_report.kind, rx_report.beacon_sub, rx_report.claim_sub,
		ring_operational, state_reg};

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= RESP_OKAY;
			unique case (s_axi_araddr[7:0] & 8'hfc)
				OFS_OPTION:   s_axi_rdata <= opt_word;
				OFS_FUNCTION: s_axi_rdata <= 32'h0000_0000;
				OFS_RROT:     s_axi_rdata <= rrot_word;
				OFS_BTYPE:    s_axi_rdata <= btype_reg;
				OFS_STATUS:   s_axi_rdata <= status_word;
				default:
				begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= RESP_SLVERR;
				end
			endcase
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// Frame classification
	always_comb
	begin
		claim_sub = CL_NONE;
		beacon_sub = BN_NONE;
		if (mac_frame.valid && mac_frame.kind == KIND_CLAIM)
		begin
			if (mac_frame.sa_match_long && mac_frame.bid == rrot_word)
				claim_sub = CL_OWN;
			else if (!mac_frame.sa_match_long && mac_frame.bid > rrot_word)
				claim_sub = CL_HIGHER;
			else if (!mac_frame.sa_match_long && mac_frame.bid < rrot_word)
				claim_sub = CL_LOWER;
		end
		if (mac_frame.valid && mac_frame.kind == KIND_BEACON)
			beacon_sub = (mac_frame.sa_match_long || mac_frame.sa_match_short) ? BN_OWN : BN_OTHER;
	end

	assign own_claim = claim_sub == CL_OWN;
	assign higher_claim = claim_sub == CL_HIGHER || (mac_frame.valid && mac_frame.kind == KIND_OTHER);
	assign lower_claim = claim_sub == CL_LOWER;
	assign own_beacon = beacon_sub == BN_OWN;
	assign other_beacon = beacon_sub == BN_OTHER;
	// Inhibit also masks own beacon as a recovery cause in Idle; in Beacon state own beacon still leads to claim
	assign recovery = !option_reg[OPT_INH_RECOV] &&
		((token_rotation_timer_expire && late_flag) || valid_transmission_timer_expire ||
		lower_claim || own_beacon);

	// Report held for the last frame only
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			rx_report <= '{kind: KIND_NONE, claim_sub: CL_NONE, beacon_sub: BN_NONE};
		else if (mac_frame.valid)
			rx_report <= '{kind: mac_frame.kind, claim_sub: claim_sub, beacon_sub: beacon_sub};
	end

	// Forced entries outrank protocol events; beacon force outranks claim force
	always_comb
	begin
		state_next = state_reg;
		issue_next = 1'b0;
		if (force_beacon_reg)
			state_next = ST_BEACON;
		else if (force_claim_reg)
			state_next = ST_CLAIM;
		else
		begin
			unique case (state_reg)
				ST_IDLE:
					if (recovery)
						state_next = ST_CLAIM;
				ST_CLAIM:
					if (token_rotation_timer_expire)
						state_next = ST_BEACON;
					else if (higher_claim)
						state_next = ST_IDLE;
					else if (own_claim && !option_reg[OPT_INH_RELEASE])
					begin
						state_next = ST_IDLE;
						issue_next = 1'b1;
					end
				ST_BEACON:
					if (other_beacon)
						state_next = ST_IDLE;
					else if (own_beacon)
						state_next = ST_CLAIM;
				default:
					state_next = ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_reg <= ST_IDLE;
			token_issue <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			token_issue <= issue_next;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			ring_operational <= 1'b0;
		else if (mac_frame.valid)
			ring_operational <= 1'b0;
		else if (token_issue)
			ring_operational <= 1'b1;
	end

	assign ring_state = state_reg;

	// One internal frame per state visit before immediate frames may go
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			sent_one_reg <= 1'b0;
		else if (state_next != state_reg || state_reg == ST_IDLE)
			sent_one_reg <= 1'b0;
		else if (gen_done)
			sent_one_reg <= 1'b1;
	end

	assign imm_grant = sent_one_reg && imm_frame_ready && is_immediate(req_class) &&
		((state_reg == ST_CLAIM && immediate_claim_qualifier) ||
		(state_reg == ST_BEACON && immediate_beacon_qualifier));

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			gen_frame <= '{valid: 1'b0, beacon: 1'b0, info: 32'h0000_0000};
		else
		begin
			gen_frame.valid <= state_next != ST_IDLE && !imm_grant;
			gen_frame.beacon <= state_next == ST_BEACON;
			gen_frame.info <= (state_next == ST_BEACON) ? btype_reg : rrot_word;
		end
	end

	// Indicator rewriting
	assign a_flag_now = option_reg[OPT_EXT_ACK] ? ext_ack_input : addr_match;
	assign e_now = fcs_error || rx_ind.sym != SYM_R;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			copy_flag_reg <= 1'b0;
		else
			copy_flag_reg <= copy_valid_input;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			e_flag_reg <= 1'b0;
			a_flag_reg <= 1'b0;
			a_rcv_s_reg <= 1'b0;
			ann_reg <= 1'b0;
		end
		else if (rx_ind.valid && rx_ind.aligned)
		begin
			if (rx_ind.pos == POS_E)
				e_flag_reg <= e_now;
			if (rx_ind.pos == POS_A)
			begin
				a_flag_reg <= a_flag_now;
				a_rcv_s_reg <= rx_ind.sym == SYM_S;
				ann_reg <= next_station_announce;
			end
		end
	end

	always_comb
	begin
		tx_sym_next = rx_ind.sym;
		if (rx_ind.aligned)
		begin
			unique case (rx_ind.pos)
				POS_E:
					if (e_now)
						tx_sym_next = SYM_S;
				POS_A:
					if (!e_flag_reg && rx_ind.sym == SYM_R && a_flag_now)
						tx_sym_next = SYM_S;
				POS_C:
					if (e_flag_reg)
						tx_sym_next = rx_ind.sym;
					else if (a_rcv_s_reg && ann_reg)
						tx_sym_next = SYM_R;
					else if (a_flag_reg)
						tx_sym_next = copy_flag_reg ? SYM_S : SYM_R;
				default:
					tx_sym_next = rx_ind.sym;
			endcase
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			tx_ind <= '{valid: 1'b0, sym: SYM_R};
		else
			tx_ind <= '{valid: rx_ind.valid, sym: tx_sym_next};
	end

	// Checks
	property p_copy_delay;
		@(posedge aclk) disable iff (!aresetn)
		copy_flag_reg == $past(copy_valid_input);
	endproperty
	a_copy_delay: assert property (p_copy_delay) else $error("copy flag not one cycle late");

	property p_e_error;
		@(posedge aclk) disable iff (!aresetn)
		rx_ind.valid && rx_ind.aligned && rx_ind.pos == POS_E && fcs_error |=> tx_ind.sym == SYM_S;
	endproperty
	a_e_error: assert property (p_e_error) else $error("E not sent as S on error");

	property p_a_set;
		@(posedge aclk) disable iff (!aresetn)
		rx_ind.valid && rx_ind.aligned && rx_ind.pos == POS_A && rx_ind.sym == SYM_R && !e_flag_reg &&
		a_flag_now |=> tx_ind.valid && tx_ind.sym == SYM_S;
	endproperty
	a_a_set: assert property (p_a_set) else $error("addressed A not set");

	property p_ann_c;
		@(posedge aclk) disable iff (!aresetn)
		rx_ind.valid && rx_ind.aligned && rx_ind.pos == POS_C && !e_flag_reg && a_rcv_s_reg && ann_reg
		|=> tx_ind.sym == SYM_R;
	endproperty
	a_ann_c: assert property (p_ann_c) else $error("announce frame C not reset");

	property p_ringop_clear;
		@(posedge aclk) disable iff (!aresetn)
		mac_frame.valid |=> !ring_operational;
	endproperty
	a_ringop_clear: assert property (p_ringop_clear) else $error("ring operational not cleared");

	property p_force_claim;
		@(posedge aclk) disable iff (!aresetn)
		force_claim_reg && !force_beacon_reg |=> state_reg == ST_CLAIM ##1 gen_frame.valid && !gen_frame.beacon;
	endproperty
	a_force_claim: assert property (p_force_claim) else $error("forced claim not entered");

	property p_higher;
		@(posedge aclk) disable iff (!aresetn)
		state_reg == ST_CLAIM && claim_sub == CL_HIGHER && !token_rotation_timer_expire && !force_claim_reg &&
		!force_beacon_reg |=> state_reg == ST_IDLE;
	endproperty
	a_higher: assert property (p_higher) else $error("higher claim did not yield");

	property p_other_beacon;
		@(posedge aclk) disable iff (!aresetn)
		state_reg == ST_BEACON && other_beacon && !force_claim_reg && !force_beacon_reg
		|=> state_reg == ST_IDLE ##1 !gen_frame.valid;
	endproperty
	a_other_beacon: assert property (p_other_beacon) else $error("beacon kept after other beacon");

	property p_own_beacon;
		@(posedge aclk) disable iff (!aresetn)
		state_reg == ST_BEACON && own_beacon && !force_claim_reg && !force_beacon_reg
		|=> state_reg == ST_CLAIM;
	endproperty
	a_own_beacon: assert property (p_own_beacon) else $error("own beacon did not lead to claim");

	property p_imm_after;
		@(posedge aclk) disable iff (!aresetn)
		imm_grant |-> sent_one_reg && $past(state_reg) == state_reg;
	endproperty
	a_imm_after: assert property (p_imm_after) else $error("immediate frame before internal one");

	property p_token;
		@(posedge aclk) disable iff (!aresetn)
		token_issue && !mac_frame.valid |=> ring_operational;
	endproperty
	a_token: assert property (p_token) else $error("token issue did not raise ring operational");

	c_claim_won: cover property (@(posedge aclk) disable iff (!aresetn) token_issue);
	c_beacon_back: cover property (@(posedge aclk) disable iff (!aresetn)
		state_reg == ST_BEACON ##1 state_reg == ST_CLAIM);
	c_imm_claim: cover property (@(posedge aclk) disable iff (!aresetn) imm_grant && state_reg == ST_CLAIM);
	c_ann: cover property (@(posedge aclk) disable iff (!aresetn)
		rx_ind.valid && rx_ind.pos == POS_C && ann_reg && a_rcv_s_reg);
endmodule

/* File: verif/rcb_ring_engine_test.sv */
// Self-checking bench for the ring claim/beacon/status engine.
// Assumes registers reached over AXI4-Lite and a far-side framer model.
`timescale 1ns/1ps
module rcb_ring_engine_test;
	import rcb_pkg::*;
	logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic awready, wready, bvalid, arready, rvalid, gen_done, imm_grant, token_issue, ring_operational;
	logic fcs_error = 0, addr_match = 0, ext_ack_input = 0, copy_valid_input = 0, next_station_announce = 0;
	logic token_rotation_timer_expire = 0, late_flag = 0, valid_transmission_timer_expire = 0, imm_frame_ready = 0;
	logic immediate_claim_qualifier = 0, immediate_beacon_qualifier = 0;
	logic [7:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata, dat, btype;
	logic [15:0] rrot;
	logic [3:0] req_class = 0;
	logic [1:0] bresp, rresp, rsp;
	rcb_ind_type rx_ind = '0;
	rcb_tx_ind_type tx_ind;
	rcb_mac_frame_type mac_frame = '0;
	rcb_gen_type gen_frame;
	rcb_state_type ring_state;
	rcb_report_type rx_report;
	int bad_count = 0, cmp_count = 0;
	rcb_ring_engine rcb_ring_engine_i (.aclk, .aresetn, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .rx_ind, .fcs_error, .addr_match,
		.ext_ack_input, .copy_valid_input, .next_station_announce, .tx_ind, .mac_frame,
		.token_rotation_timer_expire, .late_flag, .valid_transmission_timer_expire, .gen_frame, .gen_done,
		.immediate_claim_qualifier,
		.immediate_beacon_qualifier, .req_class, .imm_frame_ready, .imm_grant, .token_issue,
		.ring_operational, .ring_state, .rx_report);
	rcb_ring_model rcb_ring_model_i (.aclk, .aresetn, .gen_frame, .gen_done);
	initial forever #20 aclk = ~aclk;
	task results;
		$display("checks %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task chk(input string n, input logic [63:0] s, input logic [63:0] e);
		cmp_count++;
		if (s !== e)
		begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		do
		begin
			@(posedge aclk);
			if (awready) awvalid <= 0;
			if (wready) wvalid <= 0;
		end while (bvalid !== 1'b1);
		rsp = bresp;
		bready <= 0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		do
		begin
			@(posedge aclk);
			if (arready) arvalid <= 0;
		end while (rvalid !== 1'b1);
		dat = rdata;
		rsp = rresp;
		rready <= 0;
	endtask
	function automatic logic [5:0] exp_fs(logic [1:0] e, a, c, logic err, af, cp, n);
		logic [1:0] cc;
		cc = af ? (cp ? SYM_S : SYM_R) : c;
		if (err) return {SYM_S, a, c};
		if (a == SYM_R) return {SYM_R, af ? SYM_S : SYM_R, cc};
		return {SYM_R, SYM_S, n ? SYM_R : cc};
	endfunction
	task automatic frame(input logic opt);
		logic [1:0] e, a, c;
		logic       f, m, x, cp, n;
		logic [5:0] o;
		e = ($urandom_range(3, 0) == 0) ? SYM_S : SYM_R;
		a = 2'($urandom_range(1, 0));
		c = 2'($urandom_range(2, 0));
		{f, m, x, cp, n} = 5'($urandom);
		o = exp_fs(e, a, c, f || e != SYM_R, opt ? x : m, cp, n);
		@(posedge aclk);
		{fcs_error, addr_match, ext_ack_input, copy_valid_input, next_station_announce} <= {f, m, x, cp, n};
		rx_ind <= '{1'b1, 1'b1, POS_E, e};
		@(posedge aclk);
		rx_ind <= '{1'b1, 1'b1, POS_A, a};
		#1 chk("ind_e", tx_ind, {1'b1, o[5:4]});
		@(posedge aclk);
		rx_ind <= '{1'b1, 1'b1, POS_C, c};
		// Flip the flags: C must use what was latched or delayed at A
		{addr_match, ext_ack_input, copy_valid_input, next_station_announce} <= ~{m, x, cp, n};
		#1 chk("ind_a", tx_ind, {1'b1, o[3:2]});
		@(posedge aclk);
		rx_ind <= '0;
		#1 chk("ind_c", tx_ind, {1'b1, o[1:0]});
	endtask
	task automatic mac(input logic [1:0] k, input logic lng, input logic [31:0] bid);
		@(posedge aclk);
		// Beacons match on the short address, claims on the long one
		mac_frame <= '{1'b1, k, lng && k != KIND_BEACON, lng && k == KIND_BEACON, bid};
		@(posedge aclk);
		mac_frame <= '0;
		#1;
	endtask
	task automatic tick(input logic t);
		@(posedge aclk);
		valid_transmission_timer_expire <= !t;
		token_rotation_timer_expire <= t;
		@(posedge aclk);
		{valid_transmission_timer_expire, token_rotation_timer_expire} <= 2'h0;
		repeat (2) @(posedge aclk);
		#1;
	endtask
	task automatic force_fn(input logic [31:0] f);
		wr(OFS_FUNCTION, f);
		repeat (2) @(posedge aclk);
		#1;
	endtask
	initial
	begin
		#(40 * 30000);
		bad_count++;
		results();
	end
	initial
	begin
		dat = $urandom(1);
		rrot = 16'($urandom_range(16'hfffe, 2));
		btype = $urandom;
		repeat (16) @(posedge aclk);
		aresetn <= 1;
		wr(OFS_RROT, {16'h0, rrot});
		wr(OFS_BTYPE, btype);
		rd(OFS_FUNCTION);
		chk("function_read", dat, 0);
		wr(8'h14, 0);
		chk("unmapped_bresp", rsp, RESP_SLVERR);
		for (int p = 0; p < 2; p++)
		begin
			wr(OFS_OPTION, p);
			repeat (40) frame(p[0]);
		end
		// Misaligned symbol passes untouched even when addressed
		@(posedge aclk);
		rx_ind <= '{1'b1, 1'b0, POS_A, SYM_R};
		{addr_match, ext_ack_input} <= 2'b11;
		@(posedge aclk);
		rx_ind <= '0;
		#1 chk("ind_unaligned", tx_ind, {1'b1, SYM_R});
		wr(OFS_OPTION, 2);
		tick(0);
		chk("state_inhibit", ring_state, ST_IDLE);
		{immediate_claim_qualifier, imm_frame_ready, req_class} <= {2'b11, CLS_IMM};
		force_fn(1);
		chk("state_force_claim", ring_state, ST_CLAIM);
		chk("gen_claim", gen_frame, {2'b10, 16'h0, rrot});
		chk("grant_early", imm_grant, 0);
		for (int i = 0; i < 30 && gen_done !== 1'b1; i++) @(posedge aclk);
		#1 chk("grant_late", imm_grant, 1);
		{immediate_claim_qualifier, imm_frame_ready} <= 2'b00;
		mac(KIND_CLAIM, 0, rrot + 1);
		chk("higher", {rx_report, ring_state}, {KIND_CLAIM, CL_HIGHER, BN_NONE, ST_IDLE});
		force_fn(1);
		mac(KIND_CLAIM, 0, rrot - 1);
		chk("lower", {rx_report.claim_sub, ring_state}, {CL_LOWER, ST_CLAIM});
		mac(KIND_CLAIM, 1, rrot);
		chk("own_claim", {rx_report.claim_sub, token_issue}, {CL_OWN, 1'b1});
		@(posedge aclk);
		#1 chk("ring_op", ring_operational, 1);
		mac(KIND_OTHER, 0, 0);
		chk("ring_op_clear", ring_operational, 0);
		wr(OFS_OPTION, 0);
		tick(0);
		chk("state_tvx", ring_state, ST_CLAIM);
		tick(1);
		chk("state_trt", ring_state, ST_BEACON);
		chk("gen_beacon", gen_frame, {2'b11, btype});
		mac(KIND_BEACON, 0, 0);
		chk("other_beacon", {rx_report.beacon_sub, ring_state}, {BN_OTHER, ST_IDLE});
		mac(KIND_CLAIM, 0, rrot - 1);
		chk("lower_idle", ring_state, ST_CLAIM);
		force_fn(2);
		chk("state_force_beacon", ring_state, ST_BEACON);
		mac(KIND_BEACON, 1, 0);
		chk("own_beacon", {rx_report.beacon_sub, ring_state}, {BN_OWN, ST_CLAIM});
		wr(OFS_OPTION, 4);
		chk("report_hold", rx_report, {KIND_BEACON, CL_NONE, BN_OWN});
		mac(KIND_CLAIM, 1, rrot);
		repeat (3) @(posedge aclk);
		#1 chk("claim_kept", ring_state, ST_CLAIM);
		rd(OFS_STATUS);
		chk("status", dat, {22'h0, KIND_CLAIM, BN_NONE, CL_OWN, 1'b0, ST_CLAIM});
		results();
	end
endmodule

/* File: verif/rcb_ring_model.sv */
// Far-side framer model: answers internal frame requests with done pulses.
// Assumes the engine holds gen_frame.valid while it wants internal frames.
`timescale 1ns/1ps
module rcb_ring_model
	import rcb_pkg::*;
(
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	input  wire rcb_pkg::rcb_gen_type gen_frame,
	output logic                      gen_done
);
	int wait_cnt;
	// Random frame length, so prompt and slow framers both occur
	always_ff @(posedge aclk)
	begin
		gen_done <= 1'b0;
		if (!aresetn || !gen_frame.valid)
			wait_cnt <= 3;
		else if (wait_cnt == 0)
		begin
			gen_done <= 1'b1;
			wait_cnt <= $urandom_range(6, 0);
		end
		else
			wait_cnt <= wait_cnt - 1;
	end
endmodule
